// ---- rtl/i2cs_top.sv ----
// i2c slave-only serial interface with classic wishbone register access
// assumes an external master drives scl; pins are open drain, pulled up outside
//
// Summary of operation
// - byte done low shifting, high after eight
// - match flag shows own address comparison
// - busy set on start, cleared on stop
// - direction bit chooses transmit or receive
// - ack control bit driven on ninth clock
// - eighth bit stored as read/write flag
// - clockless mode: receive only while halted
// - received ack flag from ninth clock
// - transmit until nack, then release sda
// - one shared data register both directions
// - own address in bits seven to one
// - first seven bits are msb-first address
// - match gives interrupt, rw capture, ack
// - start is sda fall with scl high
// - scl held until data write or read
// - enable rise resets status flags only
// - timeout overflow stops, flags, interrupts
//
// The Wishbone interface to the registers and the placing of the registers are this design's own decisions.
module i2cs_top
  import i2cs_pkg::*;
#(
  parameter int unsigned TO_UNIT_CYC = TO_UNIT_CYC_DEF
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic core_halt_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  output logic irq_o
);

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ACK_ARM = 4'h2,
    ST_ACK = 4'h3,
    ST_HOLD = 4'h4,
    ST_RX = 4'h5,
    ST_TX = 4'h6,
    ST_TX_END = 4'h7,
    ST_TX_ACK = 4'h8,
    ST_WAIT_STOP = 4'h9
  } i2cs_state_t;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  i2cs_link_t lk;
  i2cs_state_t state_r;
  i2cs_status_t status_r;
  logic [2:0] mode_r;
  logic if_enable_r;
  logic en_prev_r;
  logic [7:0] data_r;
  logic [6:0] own_addr_r;
  logic to_en_r;
  logic to_flag_r;
  logic [5:0] to_sel_r;
  logic irq_en_r;
  logic [7:0] shift_r;
  logic [3:0] cnt_r;
  logic ack_low_r;
  logic pin_low_r;
  logic sda_oe_n_r;
  logic scl_oe_n_r;
  logic irq_r;
  logic ack_r;
  logic [31:0] rd_r;
  logic [31:0] rd_nxt;
  logic to_ovf;

  logic bus_req;
  logic wr_en;
  logic data_wr;
  logic data_rd;
  logic active;
  logic en_rise;
  logic ev_start;
  logic ev_stop;
  logic bit8_rise;
  logic [7:0] byte_in;
  logic addr_hit;
  logic ev_addr_byte;
  logic ev_match;
  logic ev_rx_byte;
  logic ev_tx_byte;
  logic ev_tx_ack;
  logic ev_release;
  logic tx_ok;

  i2cs_line_sync u_sync (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .link_o(lk)
  );

  i2cs_timeout #(
    .UNIT_CYC(TO_UNIT_CYC)
  ) u_timeout (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .arm_i(ev_match),
    .clear_i(lk.scl_fall),
    .stop_i(ev_stop),
    .enable_i(to_en_r),
    .sel_i(to_sel_r),
    .overflow_o(to_ovf)
  );

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr_en = bus_req & wb_we_i & wb_sel_i[0];
  assign data_wr = wr_en & hit(wb_adr_i, OFS_DATA);
  assign data_rd = bus_req & ~wb_we_i & hit(wb_adr_i, OFS_DATA);
  assign active = if_enable_r && (mode_r == MODE_I2C);
  assign en_rise = if_enable_r & ~en_prev_r;
  assign ev_start = active & lk.start;
  assign ev_stop = active & lk.stop;
  assign bit8_rise = lk.scl_rise && (cnt_r == 4'h7);
  // msb first, address in top seven
  assign byte_in = {shift_r[6:0], lk.sda};
  assign addr_hit = (byte_in[7:1] == own_addr_r);
  assign ev_addr_byte = active && (state_r == ST_ADDR) && bit8_rise;
  assign ev_match = ev_addr_byte & addr_hit;
  assign ev_rx_byte = active && (state_r == ST_RX) && bit8_rise;
  assign ev_tx_byte = active && (state_r == ST_TX) && bit8_rise;
  assign ev_tx_ack = active && (state_r == ST_TX_ACK) && lk.scl_rise;
  // release on data write or read
  assign ev_release = active && (state_r == ST_HOLD) &&
    (status_r.tx_direction_sel ? data_wr : data_rd);
  assign tx_ok = ~(status_r.clockless_run_ctrl & core_halt_i);

  // wishbone slave, one-cycle ack
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      ack_r <= 1'b0;
      rd_r <= '0;
    end
    else
    begin
      ack_r <= bus_req;
      rd_r <= bus_req ? rd_nxt : '0;
    end
  end

  always_comb
  begin
    rd_nxt = '0;
    if (hit(wb_adr_i, OFS_MODE))
    begin
      rd_nxt[7:5] = mode_r;
      rd_nxt[IF_EN_POS] = if_enable_r;
    end
    else if (hit(wb_adr_i, OFS_STATUS))
    begin
      rd_nxt[7:0] = status_r;
    end
    else if (hit(wb_adr_i, OFS_DATA))
    begin
      rd_nxt[7:0] = data_r;
    end
    else if (hit(wb_adr_i, OFS_ADDR))
    begin
      rd_nxt[7:0] = {own_addr_r, 1'b0};
    end
    else if (hit(wb_adr_i, OFS_TIMEOUT))
    begin
      rd_nxt[7:0] = {to_en_r, to_flag_r, to_sel_r};
    end
    else if (hit(wb_adr_i, OFS_IRQ))
    begin
      rd_nxt[IRQ_EN_POS] = irq_en_r;
    end
  end

  // configuration registers
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      mode_r <= MODE_POR;
      if_enable_r <= 1'b0;
      en_prev_r <= 1'b0;
      own_addr_r <= '0;
      irq_en_r <= 1'b0;
      to_sel_r <= '0;
    end
    else
    begin
      en_prev_r <= if_enable_r;
      if (wr_en && hit(wb_adr_i, OFS_MODE))
      begin
        mode_r <= wb_dat_i[MODE_POS +: 3];
        if_enable_r <= wb_dat_i[IF_EN_POS];
      end
      if (wr_en && hit(wb_adr_i, OFS_ADDR))
      begin
        own_addr_r <= wb_dat_i[7:1];
      end
      if (wr_en && hit(wb_adr_i, OFS_IRQ))
      begin
        irq_en_r <= wb_dat_i[IRQ_EN_POS];
      end
      if (wr_en && hit(wb_adr_i, OFS_TIMEOUT))
      begin
        to_sel_r <= wb_dat_i[5:0];
      end
    end
  end

  // time-out enable and flag; overflow wins over software
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      to_en_r <= 1'b0;
      to_flag_r <= 1'b0;
    end
    else if (to_ovf)
    begin
      to_en_r <= 1'b0;
      to_flag_r <= 1'b1;
    end
    else if (wr_en && hit(wb_adr_i, OFS_TIMEOUT))
    begin
      to_en_r <= wb_dat_i[TO_EN_POS];
      to_flag_r <= wb_dat_i[TO_FLAG_POS];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      data_r <= '0;
    end
    else if (ev_rx_byte)
    begin
      data_r <= byte_in;
    end
    else if (data_wr)
    begin
      data_r <= wb_dat_i[7:0];
    end
  end

  // status flags and control bits
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || to_ovf)
    begin
      status_r <= STATUS_POR;
    end
    else if (en_rise)
    begin
      status_r.byte_done_flag <= STATUS_POR.byte_done_flag;
      status_r.addr_match_flag <= STATUS_POR.addr_match_flag;
      status_r.bus_busy_flag <= STATUS_POR.bus_busy_flag;
      status_r.rw_request_flag <= STATUS_POR.rw_request_flag;
      status_r.ack_in_flag <= STATUS_POR.ack_in_flag;
    end
    else
    begin
      if (wr_en && hit(wb_adr_i, OFS_STATUS))
      begin
        status_r.tx_direction_sel <= wb_dat_i[TX_DIR_POS];
        status_r.ack_out_ctrl <= wb_dat_i[ACK_OUT_POS];
        status_r.clockless_run_ctrl <= wb_dat_i[CLOCKLESS_POS];
      end
      if (ev_start)
      begin
        status_r.bus_busy_flag <= 1'b1;
      end
      else if (ev_stop)
      begin
        status_r.bus_busy_flag <= 1'b0;
      end
      // low while shifting, high at end
      if (ev_addr_byte || ev_rx_byte || ev_tx_byte)
      begin
        status_r.byte_done_flag <= 1'b1;
      end
      else if (ev_start || ev_release)
      begin
        status_r.byte_done_flag <= 1'b0;
      end
      if (ev_match)
      begin
        status_r.addr_match_flag <= 1'b1;
      end
      else if (ev_addr_byte || ev_start || ev_release)
      begin
        status_r.addr_match_flag <= 1'b0;
      end
      if (ev_match)
      begin
        status_r.rw_request_flag <= lk.sda;
      end
      if (ev_tx_ack)
      begin
        status_r.ack_in_flag <= lk.sda;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= irq_en_r & (ev_match | ev_rx_byte | ev_tx_byte | to_ovf);
    end
  end

  // bit sequencer and pin drive
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i || !active || to_ovf || ev_stop)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      shift_r <= '0;
      ack_low_r <= 1'b0;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
    end
    else if (ev_start)
    begin
      state_r <= ST_ADDR;
      cnt_r <= '0;
      sda_oe_n_r <= 1'b1;
      scl_oe_n_r <= 1'b1;
    end
    else
    begin
      case (state_r)
        ST_ADDR:
        begin
          if (lk.scl_rise)
          begin
            shift_r <= byte_in;
            cnt_r <= cnt_r + 4'h1;
          end
          if (bit8_rise)
          begin
            ack_low_r <= 1'b1;
            state_r <= addr_hit ? ST_ACK_ARM : ST_WAIT_STOP;
          end
        end
        ST_RX:
        begin
          if (lk.scl_rise)
          begin
            shift_r <= byte_in;
            cnt_r <= cnt_r + 4'h1;
          end
          if (bit8_rise)
          begin
            ack_low_r <= ~status_r.ack_out_ctrl;
            state_r <= ST_ACK_ARM;
          end
        end
        ST_ACK_ARM:
        begin
          if (lk.scl_fall)
          begin
            sda_oe_n_r <= ~ack_low_r;
            state_r <= ST_ACK;
          end
        end
        ST_ACK:
        begin
          if (lk.scl_fall)
          begin
            sda_oe_n_r <= 1'b1;
            scl_oe_n_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD:
        begin
          if (ev_release)
          begin
            cnt_r <= '0;
            scl_oe_n_r <= 1'b1;
            if (status_r.tx_direction_sel)
            begin
              // byte written in this very cycle, data_r not yet loaded
              shift_r <= wb_dat_i[7:0];
              sda_oe_n_r <= wb_dat_i[7] | ~tx_ok;
              state_r <= ST_TX;
            end
            else
            begin
              state_r <= ST_RX;
            end
          end
        end
        ST_TX:
        begin
          if (lk.scl_rise)
          begin
            cnt_r <= cnt_r + 4'h1;
          end
          if (bit8_rise)
          begin
            state_r <= ST_TX_END;
          end
          else if (lk.scl_fall)
          begin
            shift_r <= {shift_r[6:0], 1'b0};
            sda_oe_n_r <= shift_r[6] | ~tx_ok;
          end
        end
        ST_TX_END:
        begin
          if (lk.scl_fall)
          begin
            sda_oe_n_r <= 1'b1;
            state_r <= ST_TX_ACK;
          end
        end
        ST_TX_ACK:
        begin
          if (lk.scl_fall)
          begin
            if (!status_r.ack_in_flag)
            begin
              scl_oe_n_r <= 1'b0;
              state_r <= ST_HOLD;
            end
            else
            begin
              state_r <= ST_WAIT_STOP;
            end
          end
        end
        ST_IDLE, ST_WAIT_STOP:
        begin
          sda_oe_n_r <= 1'b1;
          scl_oe_n_r <= 1'b1;
        end
        default:
        begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // pins only ever pull low
  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      pin_low_r <= 1'b0;
    end
    else
    begin
      pin_low_r <= 1'b0;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign scl_o = pin_low_r;
  assign sda_o = pin_low_r;
  assign scl_oe_n_o = scl_oe_n_r;
  assign sda_oe_n_o = sda_oe_n_r;
  assign irq_o = irq_r;

endmodule

// ---- rtl/i2cs_pkg.sv ----
// constants, register map and carrier types of the i2c slave interface
// assumes a 20 mhz core clock and a classic wishbone register bus
package i2cs_pkg;

  localparam int unsigned CORE_CLK_HZ = 20_000_000;
  // time-out unit is 32 periods of the slow sub clock
  localparam int unsigned TO_SUB_TICKS = 32;
  localparam int unsigned SUB_CLK_HZ = 32_000;
  localparam int unsigned TO_UNIT_CYC_DEF = CORE_CLK_HZ * TO_SUB_TICKS / SUB_CLK_HZ;

  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_DATA = 8'h08;
  localparam logic [7:0] OFS_ADDR = 8'h0c;
  localparam logic [7:0] OFS_TIMEOUT = 8'h10;
  localparam logic [7:0] OFS_IRQ = 8'h14;

  // serial_mode_ctrl fields
  localparam int MODE_POS = 5;
  localparam int IF_EN_POS = 1;
  localparam logic [2:0] MODE_I2C = 3'h6;
  localparam logic [2:0] MODE_POR = 3'h7;

  // bus_status_control writable bits
  localparam int TX_DIR_POS = 4;
  localparam int ACK_OUT_POS = 3;
  localparam int CLOCKLESS_POS = 1;

  // time-out control fields and interrupt enable bit
  localparam int TO_EN_POS = 7;
  localparam int TO_FLAG_POS = 6;
  localparam int IRQ_EN_POS = 0;

  typedef struct packed {
    logic byte_done_flag;
    logic addr_match_flag;
    logic bus_busy_flag;
    logic tx_direction_sel;
    logic ack_out_ctrl;
    logic rw_request_flag;
    logic clockless_run_ctrl;
    logic ack_in_flag;
  } i2cs_status_t;

  localparam i2cs_status_t STATUS_POR = i2cs_status_t'(8'h81);

  typedef struct packed {
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
  } i2cs_link_t;

endpackage

// ---- rtl/i2cs_line_sync.sv ----
// synchroniser and condition detector for the scl and sda pins
// assumes both pins are asynchronous to core_clk_i
module i2cs_line_sync
  import i2cs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output i2cs_link_t link_o
);

  logic [1:0] meta_r;
  logic [1:0] sync_r;
  logic [1:0] prev_r;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      meta_r <= 2'h3;
      sync_r <= 2'h3;
      prev_r <= 2'h3;
      link_o <= '0;
    end
    else
    begin
      meta_r <= {scl_i, sda_i};
      sync_r <= meta_r;
      prev_r <= sync_r;
      link_o.scl <= sync_r[1];
      link_o.sda <= sync_r[0];
      link_o.scl_rise <= sync_r[1] & ~prev_r[1];
      link_o.scl_fall <= ~sync_r[1] & prev_r[1];
      link_o.start <= sync_r[1] & prev_r[1] & prev_r[0] & ~sync_r[0];
      link_o.stop <= sync_r[1] & prev_r[1] & ~prev_r[0] & sync_r[0];
    end
  end

endmodule

// ---- rtl/i2cs_timeout.sv ----
// bus time-out counter, counted in units of UNIT_CYC core clocks
// assumes arm, clear and stop are single-cycle pulses from the core clock domain
module i2cs_timeout
  import i2cs_pkg::*;
#(
  parameter int unsigned UNIT_CYC = TO_UNIT_CYC_DEF
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic arm_i,
  input wire logic clear_i,
  input wire logic stop_i,
  input wire logic enable_i,
  input wire logic [5:0] sel_i,
  output logic overflow_o
);

  localparam int PW = $clog2(UNIT_CYC + 1);
  localparam logic [PW-1:0] PRE_LAST = PW'(UNIT_CYC - 1);

  logic running_r;
  logic [PW-1:0] pre_r;
  logic [5:0] units_r;

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      running_r <= 1'b0;
      pre_r <= '0;
      units_r <= '0;
      overflow_o <= 1'b0;
    end
    else
    begin
      overflow_o <= 1'b0;
      if (stop_i || !enable_i)
      begin
        running_r <= 1'b0;
      end
      else if (arm_i || clear_i)
      begin
        running_r <= running_r | arm_i;
        pre_r <= '0;
        units_r <= '0;
      end
      else if (running_r)
      begin
        if (pre_r == PRE_LAST)
        begin
          pre_r <= '0;
          units_r <= units_r + 6'h1;
          if (units_r == sel_i)
          begin
            running_r <= 1'b0;
            overflow_o <= 1'b1;
          end
        end
        else
        begin
          pre_r <= pre_r + PW'(1);
        end
      end
    end
  end

endmodule

// ---- tb/i2cs_chk.sv ----
// assertions on the i2c slave top ports
// assumes open-drain pins pulled up outside the block
module i2cs_chk
  import i2cs_pkg::*;
#(
  parameter int unsigned TO_UNIT_CYC = TO_UNIT_CYC_DEF
)
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic core_halt_i,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_n_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_n_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_read;
    s_req ##0 !wb_we_i;
  endsequence
  property p_ack;
    s_req |=> wb_ack_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("bus request not answered next cycle");
  property p_ack_drop;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_drop: assert property (p_ack_drop)
    else $error("bus ack longer than one cycle");
  property p_dat_idle;
    !wb_ack_o |-> wb_dat_o == 32'h0;
  endproperty
  a_dat_idle: assert property (p_dat_idle)
    else $error("read data not zero outside ack");
  property p_addr_bit0;
    s_read ##0 (wb_adr_i == OFS_ADDR) |=> wb_dat_o[0] == 1'b0;
  endproperty
  a_addr_bit0: assert property (p_addr_bit0)
    else $error("own address bit 0 not zero");
  property p_unmapped;
    s_read ##0 (wb_adr_i[7:2] > OFS_IRQ[7:2]) |=> wb_dat_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_pin_low;
    scl_o == 1'b0 && sda_o == 1'b0;
  endproperty
  a_pin_low: assert property (p_pin_low)
    else $error("pin output value not low");
  property p_irq_pulse;
    irq_o |=> !irq_o;
  endproperty
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("interrupt longer than one cycle");
  property p_sda_on_low;
    $changed(sda_oe_n_o) |-> !$past(scl_i);
  endproperty
  a_sda_on_low: assert property (p_sda_on_low)
    else $error("sda changed while scl high");
  property p_hold_low;
    $fell(scl_oe_n_o) |-> !$past(scl_i, 2);
  endproperty
  a_hold_low: assert property (p_hold_low)
    else $error("scl hold began with scl high");
endmodule
bind i2cs_top i2cs_chk #(.TO_UNIT_CYC(TO_UNIT_CYC)) u_chk (
  .core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .core_halt_i(core_halt_i), .scl_i(scl_i),
  .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o));

// ---- tb/i2cs_master.sv ----
// behavioural i2c bus master facing the slave
// assumes wires resolved by the bench; 8 core clocks per link clock
module i2cs_master
  import i2cs_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic scl_line_i,
  input wire logic sda_line_i,
  output logic scl_rel_o,
  output logic sda_rel_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    scl_rel_o = 1'b1;
    sda_rel_o = 1'b1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask
  // one clock pulse, 3 high 5 low, waits while the slave stretches
  task automatic pulse(output logic smp);
    cyc(4);
    scl_rel_o <= 1'b1;
    @(posedge core_clk_i);
    while (!scl_line_i)
      @(posedge core_clk_i);
    cyc(2);
    smp = sda_line_i;
    scl_rel_o <= 1'b0;
    cyc(1);
  endtask
  task automatic start_cond();
    sda_rel_o <= 1'b0;
    cyc(4);
    scl_rel_o <= 1'b0;
    cyc(2);
  endtask
  task automatic stop_cond();
    sda_rel_o <= 1'b0;
    cyc(3);
    scl_rel_o <= 1'b1;
    cyc(4);
    sda_rel_o <= 1'b1;
    cyc(4);
  endtask
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic d;
    for (int i = 7; i >= 0; i--)
    begin
      sda_rel_o <= b[i];
      pulse(d);
    end
    sda_rel_o <= 1'b1;
    pulse(ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] b);
    logic d;
    sda_rel_o <= 1'b1;
    for (int i = 7; i >= 0; i--)
    begin
      pulse(d);
      b[i] = d;
    end
    sda_rel_o <= nack;
    pulse(d);
    sda_rel_o <= 1'b1;
  endtask
endmodule

// ---- tb/i2c_slave_interface_bench.sv ----
// self-checking bench of the i2c slave with a bus master model
// assumes classic wishbone timing and a 400 ns link clock
module i2c_slave_interface_bench
  import i2cs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_i;
  logic reset_i;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic scl_o;
  logic sda_o;
  logic scl_oe_n_o;
  logic sda_oe_n_o;
  logic irq_o;
  logic core_halt_i;
  logic scl_rel;
  logic sda_rel;
  wire logic scl_w = scl_rel & scl_oe_n_o;
  wire logic sda_w = sda_rel & sda_oe_n_o;
  int err_count = 0;
  int comparisons = 0;
  int irq_cnt = 0;
  initial
  begin
    core_clk_i = 1'b0;
    forever #25 core_clk_i = ~core_clk_i;
  end
  i2cs_top #(.TO_UNIT_CYC(8)) u_i2cs_top (
    .core_clk_i(core_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .core_halt_i(core_halt_i), .scl_i(scl_w), .scl_o(scl_o),
    .scl_oe_n_o(scl_oe_n_o), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .irq_o(irq_o));
  i2cs_master u_i2cs_master (.core_clk_i(core_clk_i), .scl_line_i(scl_w),
    .sda_line_i(sda_w), .scl_rel_o(scl_rel), .sda_rel_o(sda_rel));
  always @(posedge core_clk_i)
    if (irq_o === 1'b1)
      irq_cnt <= irq_cnt + 1;
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [7:0] wd,
      output logic [7:0] rd);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, wd};
    wb_sel_i <= 4'hf;
    @(posedge core_clk_i);
    while (wb_ack_o !== 1'b1)
      @(posedge core_clk_i);
    rd = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    logic [7:0] x;
    wb_xfer(1'b1, adr, d, x);
  endtask
  task automatic rd_mask(input logic [7:0] adr, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] x;
    wb_xfer(1'b0, adr, 8'h00, x);
    chk8(x & m, e);
  endtask
  // the whole run needs under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    err_count++;
    tally_and_finish();
  end
  initial
  begin
    logic [6:0] a;
    logic [7:0] d;
    logic [7:0] g;
    logic k;
    reset_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'h0;
    core_halt_i = 1'b0;
    void'($urandom(32'hf1536020));
    repeat (3) @(posedge core_clk_i);
    reset_i <= 1'b0;
    @(posedge core_clk_i);
    rd_mask(OFS_STATUS, 8'hff, 8'h81);
    rd_mask(OFS_MODE, 8'hff, 8'he0);
    wr(8'h18, 8'h5a);
    rd_mask(8'h18, 8'hff, 8'h00);
    wr(OFS_MODE, 8'hc2);
    a = 7'($urandom);
    wr(OFS_ADDR, {a, 1'b1});
    rd_mask(OFS_ADDR, 8'hff, {a, 1'b0});
    wr(OFS_IRQ, 8'h01);
    // foreign address: no ack, no interrupt
    u_i2cs_master.start_cond();
    rd_mask(OFS_STATUS, 8'hff, 8'h21);
    u_i2cs_master.put_byte({a ^ 7'h01, 1'b0}, k);
    chk8({7'h0, k}, 8'h01);
    rd_mask(OFS_STATUS, 8'hfe, 8'ha0);
    u_i2cs_master.stop_cond();
    rd_mask(OFS_STATUS, 8'h20, 8'h00);
    chk8(8'(irq_cnt), 8'h00);
    // master writes two bytes, second refused
    u_i2cs_master.start_cond();
    u_i2cs_master.put_byte({a, 1'b0}, k);
    chk8({7'h0, k}, 8'h00);
    chk8(8'(irq_cnt), 8'h01);
    rd_mask(OFS_STATUS, 8'hfe, 8'he0);
    wr(OFS_STATUS, 8'h00);
    chk8({7'h0, scl_oe_n_o}, 8'h00);
    wb_xfer(1'b0, OFS_DATA, 8'h00, g);
    for (int n = 0; n < 2; n++)
    begin
      d = 8'($urandom);
      wr(OFS_STATUS, {4'h0, n[0], 3'h0});
      u_i2cs_master.put_byte(d, k);
      chk8({7'h0, k}, {7'h0, n[0]});
      rd_mask(OFS_STATUS, 8'hfe, {4'ha, n[0], 3'h0});
      rd_mask(OFS_DATA, 8'hff, d);
    end
    chk8(8'(irq_cnt), 8'h03);
    u_i2cs_master.stop_cond();
    rd_mask(OFS_STATUS, 8'h20, 8'h00);
    // master reads two bytes, acks then refuses
    wr(OFS_STATUS, 8'h00);
    u_i2cs_master.start_cond();
    u_i2cs_master.put_byte({a, 1'b1}, k);
    rd_mask(OFS_STATUS, 8'hfe, 8'he4);
    wr(OFS_STATUS, 8'h12);
    for (int n = 0; n < 2; n++)
    begin
      d = 8'($urandom);
      // halted core in clockless mode: transmit bits stay released
      core_halt_i <= n[0];
      wr(OFS_DATA, d);
      u_i2cs_master.get_byte(n[0], g);
      chk8(g, n[0] ? 8'hff : d);
      rd_mask(OFS_STATUS, 8'hff, {7'h5b, n[0]});
    end
    core_halt_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk8({6'h0, scl_oe_n_o, sda_oe_n_o}, 8'h03);
    u_i2cs_master.stop_cond();
    // re-enable keeps control bits
    wr(OFS_STATUS, 8'h1a);
    wr(OFS_MODE, 8'hc0);
    wr(OFS_MODE, 8'hc2);
    rd_mask(OFS_STATUS, 8'hff, 8'h9b);
    // time-out while the slave holds scl after its address
    wr(OFS_TIMEOUT, 8'h81);
    u_i2cs_master.start_cond();
    u_i2cs_master.put_byte({a, 1'b0}, k);
    repeat (30) @(posedge core_clk_i);
    rd_mask(OFS_TIMEOUT, 8'hff, 8'h41);
    rd_mask(OFS_STATUS, 8'hff, 8'h81);
    chk8({7'h0, scl_oe_n_o}, 8'h01);
    chk8(8'(irq_cnt), 8'h08);
    u_i2cs_master.stop_cond();
    tally_and_finish();
  end
endmodule
